// >>> common/sif_pkg.sv
// register map, field layout, reset values and timing for one supervised input
// assumes a 40 MHz internal clock and a byte-wide register port
package sif_pkg;

  // clock rate
  localparam int unsigned SIF_CLK_MHZ = 40;

  // register offsets
  localparam logic [7:0] SIF_OFS_OV_THRESH = 8'h40;
  localparam logic [7:0] SIF_OFS_OV_HYST = 8'h41;
  localparam logic [7:0] SIF_OFS_UV_THRESH = 8'h42;
  localparam logic [7:0] SIF_OFS_UV_HYST = 8'h43;
  localparam logic [7:0] SIF_OFS_SUPPLY_CFG = 8'h44;
  localparam logic [7:0] SIF_OFS_FUNC_SEL = 8'h45;
  localparam logic [7:0] SIF_OFS_DIN_CFG = 8'h46;
  localparam logic [7:0] SIF_OFS_IRQ_STATUS = 8'h50;
  localparam logic [7:0] SIF_OFS_IRQ_MASK = 8'h51;
  localparam logic [7:0] SIF_OFS_LIVE_STATE = 8'h52;

  // writable bit masks, reserved bits read zero
  localparam logic [7:0] SIF_MASK_HYST = 8'h1f;
  localparam logic [7:0] SIF_MASK_SUPPLY_CFG = 8'h1f;
  localparam logic [7:0] SIF_MASK_FUNC_SEL = 8'h03;
  localparam logic [7:0] SIF_MASK_DIN_CFG = 8'h7f;
  localparam logic [7:0] SIF_MASK_IRQ = 8'h07;

  // reset values
  localparam logic [7:0] SIF_RST_REG = 8'h00;

  // field positions
  localparam int unsigned SIF_POS_INVERT = 6;
  localparam int unsigned SIF_POS_DET_TYPE = 5;
  localparam int unsigned SIF_POS_PULSE_LO = 3;
  localparam int unsigned SIF_POS_DIN_GF_LO = 0;
  localparam int unsigned SIF_POS_SUP_GF_LO = 2;
  localparam int unsigned SIF_POS_FAULT_TYPE_LO = 0;

  // interrupt status bits
  localparam int unsigned SIF_IRQ_SUPPLY_FAULT = 0;
  localparam int unsigned SIF_IRQ_SUPPLY_WARN = 1;
  localparam int unsigned SIF_IRQ_DIN_FAULT = 2;

  // function selector codes
  typedef enum logic [1:0] {
    SIF_FUNC_SUPPLY_ONLY = 2'h0,
    SIF_FUNC_DIN_ONLY = 2'h1,
    SIF_FUNC_DIN_AND_WARN = 2'h2,
    SIF_FUNC_NONE = 2'h3
  } sif_func_type;

  // fault type codes
  localparam logic [1:0] SIF_FT_OVER = 2'h0;
  localparam logic [1:0] SIF_FT_EITHER = 2'h1;
  localparam logic [1:0] SIF_FT_UNDER = 2'h2;

  // times in microseconds
  localparam int unsigned SIF_PULSE_SHORT_US = 100;
  localparam int unsigned SIF_PULSE_MID_US = 1000;
  localparam int unsigned SIF_PULSE_LONG_US = 10000;
  localparam int unsigned SIF_GF_US [8] = '{0, 5, 10, 20, 30, 50, 75, 100};

  // cycle counts
  localparam int unsigned SIF_FILT_W = 12;
  localparam int unsigned SIF_PULSE_W = 19;
  localparam logic [SIF_PULSE_W-1:0] SIF_PULSE_SHORT_CYC =
    SIF_PULSE_W'(SIF_PULSE_SHORT_US * SIF_CLK_MHZ);
  localparam logic [SIF_PULSE_W-1:0] SIF_PULSE_ZERO_CYC = 19'h00001;

  // glitch filter code to cycles
  function automatic logic [SIF_FILT_W-1:0] sif_gf_cycles(input logic [2:0] code);
    sif_gf_cycles = SIF_FILT_W'(SIF_GF_US[code] * SIF_CLK_MHZ);
  endfunction : sif_gf_cycles

endpackage : sif_pkg

// >>> verilog/sif_glitch_filter.sv
// glitch filter: output follows the input once it has held for the limit
// assumes input already synchronous to i_mclk
`timescale 1ns/1ps
module sif_glitch_filter #(
  parameter int unsigned CNT_W = sif_pkg::SIF_FILT_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // data
  input wire logic i_din,
  input wire logic [CNT_W-1:0] i_limit,
  output logic o_dout
);

  typedef struct packed {
    logic dout;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lim;
  } sif_filt_state_type;

  sif_filt_state_type state_reg;
  sif_filt_state_type state_next;
  logic [CNT_W-1:0] eff_lim;

  always_comb begin
    state_next = state_reg;
    // limit is taken at the start of each interval, not mid-count
    eff_lim = (state_reg.cnt == '0) ? i_limit : state_reg.lim;
    if (i_din == state_reg.dout) begin
      state_next.cnt = '0;
    end else begin
      state_next.lim = eff_lim;
      if (state_reg.cnt >= eff_lim) begin
        state_next.dout = i_din;
        state_next.cnt = '0;
      end else begin
        state_next.cnt = state_reg.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_dout = state_reg.dout;

endmodule : sif_glitch_filter

// >>> verilog/sif_input_config.sv
// configuration registers and detection logic for one supervised input
// assumes raw comparator results and pin level arrive asynchronously
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
//
// Notes on behaviour
// - selector code 0 gives a supply fault only, 1 a digital fault only, 2 a digital fault plus a supply warning.
// - selector code 3 turns both fault paths off while the pin level stays readable.
// - the inversion bit flips the input before filtering, detection and stretching.
// - the detection type bit picks level detection when clear and edge detection when set.
// - in edge mode each rising edge yields a fixed pulse of one cycle, 100, 1000 or 10000 microseconds.
// - the glitch filter ignores pulses shorter than 0 to 100 microseconds as coded.
module sif_input_config #(
  parameter int unsigned PULSE_MID_CYC = sif_pkg::SIF_PULSE_MID_US * sif_pkg::SIF_CLK_MHZ,
  parameter int unsigned PULSE_LONG_CYC = sif_pkg::SIF_PULSE_LONG_US * sif_pkg::SIF_CLK_MHZ
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // analog side
  input wire logic i_pin,
  input wire logic i_ov_cmp,
  input wire logic i_uv_cmp,
  output logic [7:0] o_ov_trip,
  output logic [7:0] o_uv_trip,
  // detector outputs
  output logic o_supply_fault,
  output logic o_supply_warn,
  output logic o_din_fault,
  output logic o_pin_level,
  output logic o_irq
);

  localparam int unsigned PW = sif_pkg::SIF_PULSE_W;
  localparam int unsigned FW = sif_pkg::SIF_FILT_W;

  typedef struct packed {
    logic [7:0] ov_thresh;
    logic [7:0] ov_hyst;
    logic [7:0] uv_thresh;
    logic [7:0] uv_hyst;
    logic [7:0] supply_cfg;
    logic [7:0] func_sel;
    logic [7:0] din_cfg;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [1:0] pin_sync;
    logic [1:0] ov_sync;
    logic [1:0] uv_sync;
    logic din_prev;
    logic pulse_on;
    logic [PW-1:0] pulse_cnt;
    logic [PW-1:0] pulse_lim;
    logic [7:0] rdata;
    logic [7:0] ov_trip;
    logic [7:0] uv_trip;
    logic supply_fault;
    logic supply_warn;
    logic din_fault;
    logic pin_level;
    logic irq;
  } sif_state_type;

  sif_state_type state_reg;
  sif_state_type state_next;

  logic supply_raw;
  logic supply_filt;
  logic din_raw;
  logic din_filt;

  // pulse length code to cycles
  function automatic logic [PW-1:0] pulse_cycles(input logic [1:0] code);
    case (code)
      2'h0: pulse_cycles = sif_pkg::SIF_PULSE_ZERO_CYC;
      2'h1: pulse_cycles = sif_pkg::SIF_PULSE_SHORT_CYC;
      2'h2: pulse_cycles = PW'(PULSE_MID_CYC);
      default: pulse_cycles = PW'(PULSE_LONG_CYC);
    endcase
  endfunction : pulse_cycles

  // supply condition from the synchronised comparators
  always_comb begin
    case (state_reg.supply_cfg[sif_pkg::SIF_POS_FAULT_TYPE_LO +: 2])
      sif_pkg::SIF_FT_OVER: supply_raw = state_reg.ov_sync[1];
      sif_pkg::SIF_FT_EITHER: supply_raw = state_reg.ov_sync[1] | state_reg.uv_sync[1];
      sif_pkg::SIF_FT_UNDER: supply_raw = state_reg.uv_sync[1];
      default: supply_raw = 1'b0;
    endcase
  end

  assign din_raw = state_reg.pin_sync[1] ^ state_reg.din_cfg[sif_pkg::SIF_POS_INVERT];

  sif_glitch_filter #(
    .CNT_W(FW)
  ) u_supply_filter (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_din(supply_raw),
    .i_limit(sif_pkg::sif_gf_cycles(state_reg.supply_cfg[sif_pkg::SIF_POS_SUP_GF_LO +: 3])),
    .o_dout(supply_filt)
  );

  sif_glitch_filter #(
    .CNT_W(FW)
  ) u_din_filter (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_din(din_raw),
    .i_limit(sif_pkg::sif_gf_cycles(state_reg.din_cfg[sif_pkg::SIF_POS_DIN_GF_LO +: 3])),
    .o_dout(din_filt)
  );

  always_comb begin
    logic [1:0] pulse_code;
    logic din_det;
    logic [7:0] ev;
    logic [8:0] uv_sum;
    sif_pkg::sif_func_type fsel;
    pulse_code = 2'h0;
    din_det = 1'b0;
    ev = 8'h00;
    uv_sum = 9'h000;
    fsel = sif_pkg::sif_func_type'(state_reg.func_sel[1:0]);
    state_next = state_reg;

    // two-stage synchronisers
    state_next.pin_sync = {state_reg.pin_sync[0], i_pin};
    state_next.ov_sync = {state_reg.ov_sync[0], i_ov_cmp};
    state_next.uv_sync = {state_reg.uv_sync[0], i_uv_cmp};

    // register writes
    if (i_wr) begin
      case (i_addr)
        sif_pkg::SIF_OFS_OV_THRESH: state_next.ov_thresh = i_wdata;
        sif_pkg::SIF_OFS_OV_HYST: state_next.ov_hyst = i_wdata & sif_pkg::SIF_MASK_HYST;
        sif_pkg::SIF_OFS_UV_THRESH: state_next.uv_thresh = i_wdata;
        sif_pkg::SIF_OFS_UV_HYST: state_next.uv_hyst = i_wdata & sif_pkg::SIF_MASK_HYST;
        sif_pkg::SIF_OFS_SUPPLY_CFG: begin
          state_next.supply_cfg = i_wdata & sif_pkg::SIF_MASK_SUPPLY_CFG;
        end
        sif_pkg::SIF_OFS_FUNC_SEL: state_next.func_sel = i_wdata & sif_pkg::SIF_MASK_FUNC_SEL;
        sif_pkg::SIF_OFS_DIN_CFG: state_next.din_cfg = i_wdata & sif_pkg::SIF_MASK_DIN_CFG;
        sif_pkg::SIF_OFS_IRQ_MASK: state_next.irq_mask = i_wdata & sif_pkg::SIF_MASK_IRQ;
        sif_pkg::SIF_OFS_IRQ_STATUS: begin
          state_next.irq_status = state_reg.irq_status & ~(i_wdata & sif_pkg::SIF_MASK_IRQ);
        end
        default: ;
      endcase
    end

    // edge mode: rising edge of the filtered, inverted input starts a pulse
    state_next.din_prev = din_filt;
    pulse_code = state_reg.din_cfg[sif_pkg::SIF_POS_PULSE_LO +: 2];
    if (state_reg.din_cfg[sif_pkg::SIF_POS_DET_TYPE] && din_filt && !state_reg.din_prev) begin
      // length latched here so a rewrite only affects the next pulse
      state_next.pulse_lim = pulse_cycles(pulse_code);
      state_next.pulse_cnt = PW'(1);
      state_next.pulse_on = 1'b1;
    end else if (state_reg.pulse_on) begin
      if (state_reg.pulse_cnt >= state_reg.pulse_lim) begin
        state_next.pulse_on = 1'b0;
      end else begin
        state_next.pulse_cnt = state_reg.pulse_cnt + PW'(1);
      end
    end
    if (!state_reg.din_cfg[sif_pkg::SIF_POS_DET_TYPE]) begin
      state_next.pulse_on = 1'b0;
    end

    din_det = state_reg.din_cfg[sif_pkg::SIF_POS_DET_TYPE] ? state_next.pulse_on : din_filt;

    // routing by function selector
    case (fsel)
      sif_pkg::SIF_FUNC_SUPPLY_ONLY: begin
        state_next.supply_fault = supply_filt;
        state_next.supply_warn = 1'b0;
        state_next.din_fault = 1'b0;
      end
      sif_pkg::SIF_FUNC_DIN_ONLY: begin
        state_next.supply_fault = 1'b0;
        state_next.supply_warn = 1'b0;
        state_next.din_fault = din_det;
      end
      sif_pkg::SIF_FUNC_DIN_AND_WARN: begin
        state_next.supply_fault = 1'b0;
        state_next.supply_warn = supply_filt;
        state_next.din_fault = din_det;
      end
      default: begin
        state_next.supply_fault = 1'b0;
        state_next.supply_warn = 1'b0;
        state_next.din_fault = 1'b0;
      end
    endcase
    // plain pin level stays visible in every mode
    state_next.pin_level = state_reg.pin_sync[1];

    // trip points with hysteresis, saturating at the range ends
    if (state_reg.ov_sync[1]) begin
      state_next.ov_trip = (state_reg.ov_thresh > state_reg.ov_hyst) ?
        state_reg.ov_thresh - state_reg.ov_hyst : 8'h00;
    end else begin
      state_next.ov_trip = state_reg.ov_thresh;
    end
    uv_sum = {1'b0, state_reg.uv_thresh} + {1'b0, state_reg.uv_hyst};
    if (state_reg.uv_sync[1]) begin
      state_next.uv_trip = uv_sum[8] ? 8'hff : uv_sum[7:0];
    end else begin
      state_next.uv_trip = state_reg.uv_thresh;
    end

    // sticky events; a set in the clearing cycle wins
    ev[sif_pkg::SIF_IRQ_SUPPLY_FAULT] = state_next.supply_fault & ~state_reg.supply_fault;
    ev[sif_pkg::SIF_IRQ_SUPPLY_WARN] = state_next.supply_warn & ~state_reg.supply_warn;
    ev[sif_pkg::SIF_IRQ_DIN_FAULT] = state_next.din_fault & ~state_reg.din_fault;
    state_next.irq_status = state_next.irq_status | ev;
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);

    // read data valid in the cycle after the strobe only
    state_next.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        sif_pkg::SIF_OFS_OV_THRESH: state_next.rdata = state_reg.ov_thresh;
        sif_pkg::SIF_OFS_OV_HYST: state_next.rdata = state_reg.ov_hyst;
        sif_pkg::SIF_OFS_UV_THRESH: state_next.rdata = state_reg.uv_thresh;
        sif_pkg::SIF_OFS_UV_HYST: state_next.rdata = state_reg.uv_hyst;
        sif_pkg::SIF_OFS_SUPPLY_CFG: state_next.rdata = state_reg.supply_cfg;
        sif_pkg::SIF_OFS_FUNC_SEL: state_next.rdata = state_reg.func_sel;
        sif_pkg::SIF_OFS_DIN_CFG: state_next.rdata = state_reg.din_cfg;
        sif_pkg::SIF_OFS_IRQ_STATUS: state_next.rdata = state_reg.irq_status;
        sif_pkg::SIF_OFS_IRQ_MASK: state_next.rdata = state_reg.irq_mask;
        sif_pkg::SIF_OFS_LIVE_STATE: begin
          state_next.rdata = {3'h0, state_reg.pin_sync[1], state_reg.supply_fault,
                              state_reg.supply_warn, state_reg.din_fault, state_reg.pulse_on};
        end
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_reg <= '0;
      state_reg.ov_thresh <= sif_pkg::SIF_RST_REG;
      state_reg.uv_thresh <= sif_pkg::SIF_RST_REG;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_ov_trip = state_reg.ov_trip;
  assign o_uv_trip = state_reg.uv_trip;
  assign o_supply_fault = state_reg.supply_fault;
  assign o_supply_warn = state_reg.supply_warn;
  assign o_din_fault = state_reg.din_fault;
  assign o_pin_level = state_reg.pin_level;
  assign o_irq = state_reg.irq;

endmodule : sif_input_config

// >>> sim/sif_checker.sv
// checker: register map, routing, pulse and interrupt relations of one input
// assumes it is bound onto sif_input_config and sees only its ports
`timescale 1ns/1ps
module sif_checker #(
  parameter int unsigned PULSE_MID_CYC = 40000,
  parameter int unsigned PULSE_LONG_CYC = 400000
) (
  // clock, reset and register port
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // pin and detector outputs
  input wire logic i_pin,
  input wire logic o_supply_fault,
  input wire logic o_supply_warn,
  input wire logic o_din_fault,
  input wire logic o_pin_level,
  input wire logic o_irq
);
  localparam logic [7:0] MSK [8] = '{8'hff, 8'h1f, 8'hff, 8'h1f, 8'h1f, 8'h03, 8'h7f, 8'h07};
  logic [7:0] sh [8];
  logic [7:0] exp_q;
  logic [2:0] age;
  logic [19:0] run;
  wire logic [2:0] ix = (i_addr == 8'h51) ? 3'h7 : i_addr[2:0];
  wire logic hit = (i_addr[7:3] == 5'h08 && ix != 3'h7) || i_addr == 8'h51;
  wire logic [1:0] sel = sh[5][1:0];
  wire logic [7:0] cfg = sh[6];
  // shadow of the writable registers; age saturates so settling is never stale
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sh <= '{default: 8'h00};
      exp_q <= 8'h00;
      age <= 3'h0;
      run <= 20'h00000;
    end else begin
      if (i_wr && hit) begin
        sh[ix] <= i_wdata & MSK[ix];
      end
      exp_q <= hit ? sh[ix] : 8'h00;
      age <= (i_wr && (i_addr == 8'h45 || i_addr == 8'h46)) ? 3'h0 : age + {2'h0, age != 3'h7};
      run <= o_din_fault ? run + 20'h00001 : 20'h00000;
    end
  end
  function automatic int unsigned plen(input logic [1:0] c);
    case (c)
      2'h0: return 1;
      2'h1: return 4000;
      2'h2: return PULSE_MID_CYC;
      default: return PULSE_LONG_CYC;
    endcase
  endfunction : plen
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  a_read_map:
    assert property (i_rd && i_addr != 8'h50 && i_addr != 8'h52 |=> o_rdata == exp_q)
      else $error("read data mismatch");
  a_sel_off:
    assert property (sel == 2'h3 && age == 3'h7 |-> !(o_supply_fault || o_supply_warn ||
      o_din_fault)) else $error("fault active while off");
  a_route_sup:
    assert property (o_supply_fault && age == 3'h7 |-> sel == 2'h0) else $error("bad supply route");
  a_route_warn:
    assert property (o_supply_warn && age == 3'h7 |-> sel == 2'h2) else $error("bad warn route");
  a_route_din:
    assert property (o_din_fault && age == 3'h7 |-> sel[0] ^ sel[1]) else $error("bad din route");
  a_pin_sync:
    assert property ($stable(i_pin) [*5] |-> o_pin_level == i_pin) else $error("pin level lost");
  a_din_level:
    assert property ($stable(i_pin) [*8] ##0 (sel == 2'h1 && age == 3'h7 && cfg[5:0] == 6'h00)
      |-> o_din_fault == (i_pin ^ cfg[6])) else $error("level detect wrong");
  a_pulse_len:
    assert property ($fell(o_din_fault) && cfg[5] && sel == 2'h1 |-> run == 20'(plen(cfg[4:3])))
      else $error("pulse length wrong");
  a_irq_mask:
    assert property (o_irq |-> (sh[7] | $past(sh[7])) != 8'h00) else $error("irq while masked");
  c_edge: cover property ($fell(o_din_fault) && cfg[5]);
  c_irq: cover property ($rose(o_irq));
  c_warn: cover property (o_supply_warn);
endmodule : sif_checker

bind sif_input_config sif_checker #(.PULSE_MID_CYC(PULSE_MID_CYC),
  .PULSE_LONG_CYC(PULSE_LONG_CYC)) u_sif_checker (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_pin(i_pin), .o_supply_fault(o_supply_fault), .o_supply_warn(o_supply_warn),
  .o_din_fault(o_din_fault), .o_pin_level(o_pin_level), .o_irq(o_irq));

// >>> sim/testbench.sv
// testbench: register access, routing, filtering, edge pulses and interrupt
// assumes sif_checker is bound in; pulse lengths shortened for run time
`timescale 1ns/1ps
module testbench;
  localparam int unsigned MID = 50;
  localparam int unsigned LONG = 100;
  localparam int unsigned PL [4] = '{1, 4000, MID, LONG};
  localparam logic [7:0] RA [8] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h51};
  localparam logic [7:0] RM [8] = '{8'hff, 8'h1f, 8'hff, 8'h1f, 8'h1f, 8'h03, 8'h7f, 8'h07};
  logic i_mclk, i_rst_n, i_wr, i_rd, i_pin, i_ov_cmp, i_uv_cmp, rd_d, hi;
  logic [7:0] i_addr, i_wdata, o_rdata, lf, o_ov_trip, o_uv_trip;
  logic o_supply_fault, o_supply_warn, o_din_fault, o_pin_level, o_irq;
  logic [15:0] q [$];
  int n_errors, n_tests, cyc_n, n, lim;
  sif_input_config #(.PULSE_MID_CYC(MID), .PULSE_LONG_CYC(LONG)) u_sif_input_config (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin), .i_ov_cmp(i_ov_cmp), .i_uv_cmp(i_uv_cmp),
    .o_ov_trip(o_ov_trip), .o_uv_trip(o_uv_trip), .o_supply_fault(o_supply_fault),
    .o_supply_warn(o_supply_warn), .o_din_fault(o_din_fault), .o_pin_level(o_pin_level),
    .o_irq(o_irq));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {15'h0, e}, {15'h0, g});
  endtask : chk1
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  // expected value queued when the read is issued, compared by the watcher
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    q.push_back({8'h00, e});
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask : rd
  task automatic pin(input logic v);
    @(posedge i_mclk);
    i_pin <= v;
  endtask : pin
  task automatic cyc(input int k);
    repeat (k) @(negedge i_mclk);
  endtask : cyc
  task automatic mon(input int k);
    repeat (k) begin
      @(negedge i_mclk);
      hi = hi | o_din_fault;
    end
  endtask : mon
  task automatic results();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (rd_d) begin
      chk("rdata", q.pop_front(), {8'h00, o_rdata});
    end
    rd_d <= i_rd;
    cyc_n++;
    if (cyc_n == 80000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_pin, i_ov_cmp, i_uv_cmp} = '0;
    {i_addr, i_wdata} = '0;
    lf = 8'h2f;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      lf = nxt(lf);
      wr(RA[a], lf);
      rd(RA[a], lf & RM[a]);
    end
    wr(8'h60, lf);
    rd(8'h60, 8'h00);
    rd(8'h47, 8'h00);
    wr(8'h44, 8'h00);
    wr(8'h46, 8'h00);
    wr(8'h51, 8'h00);
    i_ov_cmp <= 1'b1;
    pin(1'b1);
    for (int s = 0; s < 4; s++) begin
      wr(8'h45, 8'(s));
      cyc(12);
      chk1("sup", s == 0, o_supply_fault);
      chk1("warn", s == 2, o_supply_warn);
      chk1("din", s == 1 || s == 2, o_din_fault);
      chk1("pin", 1'b1, o_pin_level);
      rd(8'h52, {3'h0, 1'b1, s == 0, s == 2, s == 1 || s == 2, 1'b0});
    end
    i_ov_cmp <= 1'b0;
    pin(1'b0);
    wr(8'h45, 8'h01);
    cyc(12);
    wr(8'h50, 8'h07);
    rd(8'h50, 8'h00);
    pin(1'b1);
    cyc(12);
    rd(8'h50, 8'h04);
    chk1("irq", 1'b0, o_irq);
    wr(8'h51, 8'h04);
    cyc(4);
    chk1("irq", 1'b1, o_irq);
    wr(8'h50, 8'h04);
    cyc(4);
    chk1("irq", 1'b0, o_irq);
    wr(8'h46, 8'h40);
    cyc(12);
    chk1("din", 1'b0, o_din_fault);
    pin(1'b0);
    cyc(12);
    chk1("din", 1'b1, o_din_fault);
    // start the glitch runs from a low fault, else the first run sees a stale high
    wr(8'h46, 8'h00);
    cyc(12);
    for (int c = 1; c < 8; c++) begin
      lim = sif_pkg::SIF_GF_US[c] * sif_pkg::SIF_CLK_MHZ;
      wr(8'h46, 8'(c));
      hi = 1'b0;
      pin(1'b1);
      mon(lim - 20);
      pin(1'b0);
      mon(lim + 20);
      chk1("glitch", 1'b0, hi);
      pin(1'b1);
      cyc(lim + 20);
      chk1("filtered", 1'b1, o_din_fault);
      pin(1'b0);
      cyc(lim + 20);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h46, {3'h1, 2'(c), 3'h0});
      pin(1'b1);
      n = 0;
      repeat (20) if (o_din_fault !== 1'b1) @(negedge i_mclk);
      while (o_din_fault === 1'b1 && n < 5000) begin
        n++;
        @(negedge i_mclk);
      end
      chk("pulse", 16'(PL[c]), 16'(n));
      pin(1'b0);
      cyc(10);
    end
    // fault type decoding: odd runs raise only undervoltage, even runs only overvoltage
    wr(8'h45, 8'h00);
    for (int t = 0; t < 8; t++) begin
      wr(8'h44, 8'(t[2:1]));
      i_ov_cmp <= !t[0];
      i_uv_cmp <= t[0];
      cyc(12);
      chk1("ftype", t[0] ? (t[2:1] == 2'h1 || t[2:1] == 2'h2) : (t[2:1] < 2'h2), o_supply_fault);
    end
    // trip points: plain thresholds, then hysteresis with only the undervoltage trip saturating at 0xff
    wr(8'h40, 8'h80);
    wr(8'h41, 8'h15);
    wr(8'h42, 8'hf0);
    wr(8'h43, 8'h1f);
    {i_ov_cmp, i_uv_cmp} <= 2'h0;
    cyc(8);
    chk("ov_trip", 16'h0080, {8'h00, o_ov_trip});
    chk("uv_trip", 16'h00f0, {8'h00, o_uv_trip});
    @(posedge i_mclk);
    {i_ov_cmp, i_uv_cmp} <= 2'h3;
    cyc(8);
    chk("ov_trip", 16'h006b, {8'h00, o_ov_trip});
    chk("uv_trip", 16'h00ff, {8'h00, o_uv_trip});
    results();
  end
endmodule : testbench
